// ---- rtl/jpeg_regs_pkg.sv ----
// Shared offsets, fields, reset values and carrier types of the JPEG status/config bank
`default_nettype none
package jpeg_regs_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] REG_STATUS_TABLE_LEN_HI = 8'h02;
  localparam logic [7:0] REG_ENCODED_LENGTH_LOW = 8'h03;
  localparam logic [7:0] REG_FIFO_FULLNESS = 8'h04;
  localparam logic [7:0] REG_FRONT_END_CONFIG = 8'h05;
  localparam logic [7:0] REG_CORE_QUANT_EXTEND = 8'h06;
  localparam logic [7:0] REG_ENCODER_BYPASS = 8'h0a;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int QSEL_LSB = 6;
  localparam int LEN_HI_LSB = 8;
  localparam int LEN_WIDTH = 24;
  localparam int FE_WIDTH = 6;
  localparam int FE_CHROMA420_BIT = 0;
  localparam int FE_MONO_BIT = 1;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [5:0] FRONT_END_CONFIG_RST = 6'h00;
  localparam logic CORE_QUANT_EXTEND_RST = 1'b0;
  localparam logic ENCODER_BYPASS_RST = 1'b1;
  localparam logic [1:0] QSET_THIRD = 2'h2;
  localparam logic [2:0] FULLNESS_EMPTY = 3'h0;
  localparam logic [2:0] FULLNESS_Q1 = 3'h1;
  localparam logic [2:0] FULLNESS_Q2 = 3'h3;
  localparam logic [2:0] FULLNESS_Q3 = 3'h2;
  localparam logic [2:0] FULLNESS_Q4 = 3'h6;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic chroma;
    logic [7:0] data;
  } pix_t;

  typedef enum logic [1:0] {OUT_IDLE, OUT_LINE, OUT_PAD} out_state_t;
endpackage
`default_nettype wire

// ---- rtl/jpeg_status_config_regs.sv ----
// JPEG status/configuration register bank with output FIFO, bypass routing and spoof framing
// Contract
// - The table select field reports set 0, 1 or 2 as 00, 01, 10 and never the reserved 11.
// - A 24-bit sent-byte count shows bits 23:16 in reg 2 [15:8] and bits 15:0 in reg 3.
// - After an output FIFO overflow the byte count freezes at the bytes already sent.
// - Reg 4 gives the FIFO level as 000, 001, 011, 010, 110 for empty and each quarter.
// - Front-end bit 0 picks 4:2:2 (0) or 4:2:0 (1) sampling for the encoder.
// - With the monochrome bit set only luma samples go to the encoder; chroma is dropped.
// - The extend bit selects the third table pair; clearing it returns to the programmed set.
// - With bypass set (reset value 1) raw frames go through the FIFO and out as spoof frames.
// - With bypass clear the encoder's compressed bytes go through the FIFO to the output.
// - With spoof framing on, lines are shaped to the spoof width and padded with dummy bytes.
`default_nettype none

// ****************************************
// Output FIFO
// ****************************************
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Fill side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] next_level;
  logic push, pop;

  assign wr_ready = level != (PW+1)'(DEPTH);
  assign rd_valid = level != '0;
  assign rd_data = mem[rd_ptr];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_level = level + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= wr_data;
    end
  end
endmodule

// ****************************************
// Register bank and data routing
// ****************************************
module jpeg_status_config_regs import jpeg_regs_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  // Quantization table selection
  input wire logic programmed_set,
  output logic [1:0] quant_table_select,
  // Front-end configuration to the encoder
  output logic chroma_420,
  // Raw pixel stream in
  input wire logic raw_valid,
  input wire pix_t raw_pix,
  output logic raw_ready,
  // Samples to the encoder
  output logic enc_in_valid,
  output logic [7:0] enc_in_data,
  input wire logic enc_in_ready,
  // Compressed bytes from the encoder
  input wire logic enc_out_valid,
  input wire logic [7:0] enc_out_data,
  output logic enc_out_ready,
  // Frame control and spoof settings
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic spoof_enable,
  input wire logic [15:0] spoof_width,
  // Output stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_line_end,
  output logic frame_valid,
  input wire logic out_ready,
  // Status
  output logic fifo_overflow
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [FE_WIDTH-1:0] front_end_config, next_front_end_config;
  logic core_quant_extend, next_core_quant_extend;
  logic encoder_bypass, next_encoder_bypass;
  logic [15:0] next_reg_rdata;
  logic [LEN_WIDTH-1:0] byte_count, next_byte_count;
  logic next_fifo_overflow;
  out_state_t state, next_state;
  logic [15:0] col, next_col;
  logic src_done, next_src_done;
  logic next_out_valid, next_out_line_end;
  logic [7:0] next_out_data;
  logic mono, drop_chroma, advance, pop, line_last;
  logic fifo_wr_valid, fifo_wr_ready, fifo_rd_valid;
  logic [7:0] fifo_wr_data, fifo_rd_data;
  logic [LW-1:0] fifo_level;
  logic [2:0] fullness;

  function automatic logic [2:0] fullness_code(input int unsigned lvl, input int unsigned dep);
    if (lvl == 0) fullness_code = FULLNESS_EMPTY;
    else if (lvl * 4 < dep) fullness_code = FULLNESS_Q1;
    else if (lvl * 4 < dep * 2) fullness_code = FULLNESS_Q2;
    else if (lvl * 4 < dep * 3) fullness_code = FULLNESS_Q3;
    else fullness_code = FULLNESS_Q4;
  endfunction

  // ****************************************
  // Routing between raw input, encoder and FIFO
  // ****************************************
  assign mono = front_end_config[FE_MONO_BIT];
  assign chroma_420 = front_end_config[FE_CHROMA420_BIT];
  assign quant_table_select = core_quant_extend ? QSET_THIRD : {1'b0, programmed_set};
  assign drop_chroma = mono && raw_pix.chroma;
  // Bypass switches the FIFO source at once; change it only between frames
  assign enc_in_valid = !encoder_bypass && raw_valid && !drop_chroma;
  assign enc_in_data = raw_pix.data;
  assign fifo_wr_valid = encoder_bypass ? raw_valid : enc_out_valid;
  assign fifo_wr_data = encoder_bypass ? raw_pix.data : enc_out_data;
  assign enc_out_ready = !encoder_bypass && fifo_wr_ready;
  assign raw_ready = encoder_bypass ? fifo_wr_ready : (drop_chroma || enc_in_ready);
  assign fullness = fullness_code(int'(fifo_level), FIFO_DEPTH);
  assign frame_valid = (state != OUT_IDLE) || out_valid;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_valid(fifo_wr_valid),
    .wr_data(fifo_wr_data),
    .wr_ready(fifo_wr_ready),
    .rd_valid(fifo_rd_valid),
    .rd_data(fifo_rd_data),
    .rd_ready(pop),
    .level(fifo_level)
  );

  // ****************************************
  // Register access
  // ****************************************
  always_comb begin
    next_front_end_config = front_end_config;
    next_core_quant_extend = core_quant_extend;
    next_encoder_bypass = encoder_bypass;
    next_reg_rdata = reg_rdata;
    // Count and fullness offsets fall to the default: writes there do nothing
    if (reg_req.write) begin
      case (reg_req.addr)
        REG_FRONT_END_CONFIG: next_front_end_config = reg_req.wdata[FE_WIDTH-1:0];
        REG_CORE_QUANT_EXTEND: next_core_quant_extend = reg_req.wdata[0];
        REG_ENCODER_BYPASS: next_encoder_bypass = reg_req.wdata[0];
        default: ;
      endcase
    end
    if (reg_req.read) begin
      case (reg_req.addr)
        REG_STATUS_TABLE_LEN_HI: begin
          next_reg_rdata = '0;
          next_reg_rdata[LEN_HI_LSB +: 8] = byte_count[23:16];
          next_reg_rdata[QSEL_LSB +: 2] = quant_table_select;
        end
        REG_ENCODED_LENGTH_LOW: next_reg_rdata = byte_count[15:0];
        REG_FIFO_FULLNESS: next_reg_rdata = {13'h0000, fullness};
        REG_FRONT_END_CONFIG: next_reg_rdata = {10'h000, front_end_config};
        REG_CORE_QUANT_EXTEND: next_reg_rdata = {15'h0000, core_quant_extend};
        REG_ENCODER_BYPASS: next_reg_rdata = {15'h0000, encoder_bypass};
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      front_end_config <= FRONT_END_CONFIG_RST;
      core_quant_extend <= CORE_QUANT_EXTEND_RST;
      encoder_bypass <= ENCODER_BYPASS_RST;
      reg_rdata <= '0;
    end else if (ce) begin
      front_end_config <= next_front_end_config;
      core_quant_extend <= next_core_quant_extend;
      encoder_bypass <= next_encoder_bypass;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // Output framing, byte count and overflow
  // ****************************************
  assign advance = !out_valid || out_ready;
  assign line_last = spoof_enable && (col == spoof_width - 16'h0001);

  always_comb begin
    next_state = state;
    next_col = col;
    next_src_done = src_done || frame_end;
    next_out_valid = out_valid && !out_ready;
    next_out_data = out_data;
    next_out_line_end = out_line_end;
    next_byte_count = byte_count;
    next_fifo_overflow = fifo_overflow;
    pop = 1'b0;
    case (state)
      OUT_IDLE: begin
        if (frame_start) begin
          next_state = OUT_LINE;
          next_col = '0;
          next_src_done = frame_end;
          next_byte_count = '0;
          next_fifo_overflow = 1'b0;
        end
      end
      OUT_LINE: begin
        if (advance && fifo_rd_valid) begin
          pop = 1'b1;
          next_out_valid = 1'b1;
          next_out_data = fifo_rd_data;
          next_out_line_end = line_last || !spoof_enable;
          next_col = line_last ? '0 : col + 16'h0001;
          if (!fifo_overflow) begin
            next_byte_count = byte_count + LEN_WIDTH'(1);
          end
        end else if (advance && src_done) begin
          // A short last line is completed with dummy bytes
          next_state = (spoof_enable && col != '0) ? OUT_PAD : OUT_IDLE;
        end
      end
      OUT_PAD: begin
        if (advance) begin
          next_out_valid = 1'b1;
          next_out_data = DUMMY_BYTE;
          next_out_line_end = line_last;
          next_col = line_last ? '0 : col + 16'h0001;
          if (line_last) begin
            next_state = OUT_IDLE;
          end
        end
      end
      default: next_state = OUT_IDLE;
    endcase
    // An overflow in the very cycle of a frame start still counts
    if (!encoder_bypass && enc_out_valid && !fifo_wr_ready) begin
      next_fifo_overflow = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= OUT_IDLE;
      col <= '0;
      src_done <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
      out_line_end <= 1'b0;
      byte_count <= '0;
      fifo_overflow <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      col <= next_col;
      src_done <= next_src_done;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      out_line_end <= next_out_line_end;
      byte_count <= next_byte_count;
      fifo_overflow <= next_fifo_overflow;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce);

  a_qsel_not_reserved: assert property (quant_table_select != 2'h3)
    else $error("table select shows the reserved code");
  a_len_low_read: assert property (ce && reg_req.read && reg_req.addr == REG_ENCODED_LENGTH_LOW
    |=> reg_rdata == $past(byte_count[15:0])) else $error("length low readback wrong");
  a_count_frozen: assert property (fifo_overflow && state != OUT_IDLE |=> byte_count == $past(byte_count))
    else $error("byte count moved after overflow");
  a_fullness_full: assert property (fifo_level == LW'(FIFO_DEPTH) |-> fullness == FULLNESS_Q4)
    else $error("full FIFO not coded 110");
  a_chroma_fmt_write: assert property (ce && reg_req.write && reg_req.addr == REG_FRONT_END_CONFIG
    |=> chroma_420 == $past(reg_req.wdata[0])) else $error("sampling format not taken");
  a_mono_drop: assert property (mono && raw_pix.chroma |-> !enc_in_valid)
    else $error("chroma reached the encoder in monochrome mode");
  a_extend_third: assert property (ce && reg_req.write && reg_req.addr == REG_CORE_QUANT_EXTEND && reg_req.wdata[0]
    |=> quant_table_select == QSET_THIRD) else $error("third table pair not selected");
  a_bypass_route: assert property (encoder_bypass && raw_valid |-> fifo_wr_valid && !enc_in_valid)
    else $error("raw data not routed to FIFO in bypass");
  a_encoded_route: assert property (!encoder_bypass |-> fifo_wr_valid == enc_out_valid && !enc_out_ready == !fifo_wr_ready)
    else $error("compressed data not routed to FIFO");
  a_pad_dummy: assert property (state == OUT_PAD && advance |=> out_valid && out_data == DUMMY_BYTE)
    else $error("padding byte not dummy");
  a_count_ro: assert property (ce && reg_req.write && reg_req.addr == REG_ENCODED_LENGTH_LOW && !pop && state != OUT_IDLE
    |=> byte_count == $past(byte_count)) else $error("write changed the byte count");

  c_bypass_frame: cover property (encoder_bypass && pop ##[1:40] state == OUT_IDLE);
  c_overflow: cover property (!fifo_overflow ##1 fifo_overflow);
  c_padding: cover property (state == OUT_PAD ##1 out_valid && out_line_end);
  c_fifo_full: cover property (!fifo_wr_ready);
endmodule
`default_nettype wire

// ---- verif/out_sink.sv ----
// Output sink model that stalls on command and logs every byte it accepts
`default_nettype none
module out_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Output stream from the block
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_line_end,
  output logic out_ready,
  // Bench control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Acceptance log
  // ****************************************
  // Each entry is {line_end, data}
  logic [8:0] got[$];
  assign out_ready = !stall;
  always @(posedge clk) begin
    if (!reset && out_valid && out_ready) begin
      got.push_back({out_line_end, out_data});
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the JPEG status and configuration bank
`default_nettype none
module tb_top import jpeg_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic wr; logic [7:0] waddr; logic [15:0] wdata; logic pset; logic [7:0] raddr; logic [15:0] exp;} row_t;
  logic clk = 0, reset = 1, ce = 1, programmed_set = 0, chroma_420, raw_valid = 0, raw_ready;
  reg_req_t reg_req = '0;
  pix_t raw_pix = '0;
  logic [15:0] reg_rdata, rd, spoof_width = 16'h0003;
  logic [1:0] quant_table_select;
  logic enc_in_valid, enc_in_ready = 1, enc_out_valid = 0, enc_out_ready, frame_start = 0, frame_end = 0;
  logic [7:0] enc_in_data, enc_out_data = 8'h00, out_data;
  logic spoof_enable = 0, out_valid, out_line_end, frame_valid, out_ready, fifo_overflow, stall = 1;
  int miscompares = 0, n_tests = 0;
  row_t rows[13] = '{
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h0a, 16'h0001},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h05, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h06, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h03, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h04, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 8'h07, 16'h0000},
    '{1'b0, 8'h00, 16'h0000, 1'b1, 8'h02, 16'h0040},
    '{1'b1, 8'h06, 16'h0001, 1'b1, 8'h02, 16'h0080},
    '{1'b1, 8'h06, 16'h0000, 1'b0, 8'h02, 16'h0000},
    '{1'b1, 8'h05, 16'h003f, 1'b0, 8'h05, 16'h003f},
    '{1'b1, 8'h03, 16'hffff, 1'b0, 8'h03, 16'h0000},
    '{1'b1, 8'h04, 16'h0007, 1'b0, 8'h04, 16'h0000},
    '{1'b1, 8'h02, 16'hffff, 1'b1, 8'h02, 16'h0040}};

  jpeg_status_config_regs #(.FIFO_DEPTH(4)) jpeg_status_config_regs_i (
    .clk(clk), .reset(reset), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .programmed_set(programmed_set), .quant_table_select(quant_table_select), .chroma_420(chroma_420),
    .raw_valid(raw_valid), .raw_pix(raw_pix), .raw_ready(raw_ready), .enc_in_valid(enc_in_valid),
    .enc_in_data(enc_in_data), .enc_in_ready(enc_in_ready), .enc_out_valid(enc_out_valid),
    .enc_out_data(enc_out_data), .enc_out_ready(enc_out_ready), .frame_start(frame_start),
    .frame_end(frame_end), .spoof_enable(spoof_enable), .spoof_width(spoof_width), .out_valid(out_valid),
    .out_data(out_data), .out_line_end(out_line_end), .frame_valid(frame_valid), .out_ready(out_ready),
    .fifo_overflow(fifo_overflow));
  out_sink out_sink_i (.clk(clk), .reset(reset), .out_valid(out_valid), .out_data(out_data),
    .out_line_end(out_line_end), .out_ready(out_ready), .stall(stall));

  always #12.5 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    tick();
    reg_req = '{1'b1, 1'b0, a, d};
    tick();
    reg_req = '0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    tick();
    reg_req = '{1'b0, 1'b1, a, 16'h0000};
    tick();
    reg_req = '0;
    d = reg_rdata;
  endtask
  task automatic pulse_frame(input logic start);
    tick();
    if (start) frame_start = 1;
    else frame_end = 1;
    tick();
    frame_start = 0;
    frame_end = 0;
  endtask
  task automatic push_raw(input logic [7:0] d);
    tick();
    raw_valid = 1;
    raw_pix = '{1'b0, d};
    for (int i = 0; i < 50 && raw_ready !== 1'b1; i++) tick();
    check(raw_ready, 1'b1, "raw byte not accepted");
    tick();
    raw_valid = 0;
  endtask
  task automatic push_enc(input logic [7:0] d);
    tick();
    enc_out_valid = 1;
    enc_out_data = d;
    for (int i = 0; i < 50 && enc_out_ready !== 1'b1; i++) tick();
    check(enc_out_ready, 1'b1, "encoder byte not accepted");
    tick();
    enc_out_valid = 0;
  endtask
  task automatic drain();
    stall = 0;
    for (int i = 0; i < 200 && frame_valid !== 1'b0; i++) tick();
    check(frame_valid, 1'b0, "frame did not end");
  endtask
  // Expected fullness code of a level, by quarters of the depth
  function automatic logic [2:0] fcode(input int l);
    if (l == 0) return 3'h0;
    if (4 * l < 4) return 3'h1;
    if (4 * l < 8) return 3'h3;
    if (4 * l < 12) return 3'h2;
    return 3'h6;
  endfunction
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  // The whole sequence needs a few hundred cycles; this leaves ample margin
  initial begin
    #(25 * 20000);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 0;
    foreach (rows[i]) begin
      programmed_set = rows[i].pset;
      if (rows[i].wr) reg_write(rows[i].waddr, rows[i].wdata);
      reg_read(rows[i].raddr, rd);
      check(rd, rows[i].exp, "register row");
    end
    // Table set 0 is the programmed one from here on
    programmed_set = 0;
    reg_write(8'h05, 16'h0001);
    tick();
    check(chroma_420, 1'b1, "4:2:0 select");
    reg_write(8'h05, 16'h0000);
    reg_write(8'h06, 16'h0001);
    tick();
    check(chroma_420, 1'b0, "4:2:2 select");
    check(quant_table_select, QSET_THIRD, "third table pair");
    reg_write(8'h06, 16'h0000);
    tick();
    check(quant_table_select, 2'h0, "back to programmed set");
    // A write while the clock enable is low must not land
    ce = 0;
    reg_write(8'h06, 16'h0001);
    ce = 1;
    reg_read(8'h06, rd);
    check(rd, 16'h0000, "write ignored while ce low");
    // Bypass frame: the first byte sits in the output register, the rest fill the FIFO
    spoof_enable = 1;
    pulse_frame(1);
    for (int k = 0; k < 5; k++) begin
      push_raw(8'h10 + k);
      repeat (3) tick();
      reg_read(8'h04, rd);
      check(rd, {13'h0, fcode(k)}, "fullness code");
    end
    check(raw_ready, 1'b0, "full FIFO must refuse");
    pulse_frame(0);
    drain();
    check(out_sink_i.got.size(), 16'd6, "spoof frame length");
    for (int j = 0; j < 6 && j < out_sink_i.got.size(); j++) begin
      check(out_sink_i.got[j], {7'h0, j % 3 == 2, j < 5 ? 8'(8'h10 + j) : DUMMY_BYTE}, "spoof byte");
    end
    // Encoder path with monochrome dropping chroma
    reg_write(8'h0a, 16'h0000);
    reg_write(8'h05, 16'h0002);
    spoof_enable = 0;
    tick();
    raw_valid = 1;
    raw_pix = '{1'b1, 8'h55};
    #1;
    check(enc_in_valid, 1'b0, "chroma dropped");
    check(raw_ready, 1'b1, "chroma consumed");
    tick();
    raw_pix = '{1'b0, 8'h66};
    #1;
    check(enc_in_valid, 1'b1, "luma forwarded");
    check(enc_in_data, 8'h66, "luma data");
    tick();
    raw_valid = 0;
    out_sink_i.got.delete();
    pulse_frame(1);
    for (int k = 0; k < 3; k++) push_enc(8'ha0 + k);
    pulse_frame(0);
    drain();
    check(out_sink_i.got.size(), 16'd3, "compressed length");
    for (int j = 0; j < 3 && j < out_sink_i.got.size(); j++) begin
      check(out_sink_i.got[j], {8'h01, 8'(8'ha0 + j)}, "compressed byte");
    end
    reg_read(8'h03, rd);
    check(rd, 16'h0003, "byte count low");
    reg_read(8'h02, rd);
    check(rd, 16'h0000, "byte count high");
    // Overflow freezes the count at the single byte already sent
    stall = 1;
    pulse_frame(1);
    tick();
    enc_out_valid = 1;
    enc_out_data = 8'hc3;
    repeat (10) tick();
    enc_out_valid = 0;
    check(fifo_overflow, 1'b1, "overflow flag");
    reg_read(8'h03, rd);
    check(rd, 16'h0001, "count at overflow");
    pulse_frame(0);
    drain();
    reg_read(8'h03, rd);
    check(rd, 16'h0001, "count frozen after drain");
    pulse_frame(1);
    check(fifo_overflow, 1'b0, "overflow cleared by new frame");
    pulse_frame(0);
    drain();
    // Second reset in mid-run restores the bypass default
    tick();
    reset = 1;
    repeat (2) tick();
    reset = 0;
    reg_read(8'h0a, rd);
    check(rd, 16'h0001, "bypass after reset");
    summarize();
  end
endmodule
`default_nettype wire
